// file: src/intr_accept.sv
// Interrupt acceptance and dispatch logic
// ------------------------------------------------------------
// Summary of operation
// - All sources maskable except NMI and three fault sources
// - Each maskable request gated by own mask bit
// - Service-off instruction suspends all maskable servicing
// - Nonmaskables ignore masks, never go to server
// - Service off/on leave nonmaskables untouched
// - Opcode and trap faults bypass priority, vector directly when executed; stack overflow goes through priority
// - Protected instruction delays acknowledge one instruction
// - Protected set: service, server, save, restore
// - Status high byte: enable, server enable, flags
// - Status low byte is the mask register
// - Save/restore-all moves both status bytes
// - Save/restore-flags moves only the high byte
// - Event array requests get distinct vectors
// - Server runs routine from control block
// - Server request fetches control block address
// - One server cycle moves one byte or word
// - Standard request reads vector for routine
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module intr_accept #(
    parameter int NM = intr_accept_pkg::NUM_MASKABLE
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_nrst,
    // Register port
    input  wire logic [3:0]           i_reg_addr,
    input  wire logic [15:0]          i_reg_wdata,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    output logic [15:0]               o_reg_rdata,
    // Request sources
    input  wire logic [NM-1:0]        i_mask_req,
    input  wire logic                 i_nmi_req,
    input  wire logic                 i_stack_ovf_req,
    // Microcode engine
    input  wire logic                 i_instr_done,
    input  wire logic [3:0]           i_instr_class,
    input  wire logic [15:0]          i_pop_data,
    input  wire logic                 i_ack_point,
    input  wire logic                 i_ts_xfer_done,
    output logic                      o_dispatch,
    output logic [1:0]                o_dispatch_kind,
    output logic [15:0]               o_vector_addr,
    output logic [15:0]               o_push_data,
    output logic                      o_push_two_bytes,
    output logic                      o_ts_xfer_req,
    output logic                      o_irq
);

    localparam int NP  = NM + 2;
    localparam int EVW = intr_accept_pkg::EV_W;

    typedef struct packed {
        logic [15:0]    processor_status_word;
        logic [NM-1:0]  route;
        logic [NM-1:0]  pend;
        logic           nmi_pend;
        logic           ovf_pend;
        logic           hold;
        logic           ts_busy;
        logic [EVW-1:0] ev_st;
        logic [EVW-1:0] ev_msk;
        logic [15:0]    last_vec;
        logic [15:0]    rdata;
        logic           disp;
        logic [1:0]     kind;
        logic [15:0]    vec;
        logic [15:0]    push;
        logic           push2;
        logic           xfer;
        logic           irq;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    logic [1:0] nmi_sync_r;
    logic [1:0] ovf_sync_r;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic is_protected(input logic [3:0] c);
        is_protected = (c >= intr_accept_pkg::INS_SRV_OFF) &&
                       (c <= intr_accept_pkg::INS_REST_FLAGS);
    endfunction

    function automatic logic [15:0] std_vec(input logic [3:0] i);
        std_vec = intr_accept_pkg::VEC_BASE_STD + {11'h000, i, 1'b0};
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers for nonmaskable sources
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            nmi_sync_r <= 2'b00;
            ovf_sync_r <= 2'b00;
        end else begin
            nmi_sync_r <= {nmi_sync_r[0], i_nmi_req};
            ovf_sync_r <= {ovf_sync_r[0], i_stack_ovf_req};
        end
    end

    // ------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------
    logic [NM-1:0] mask_ok;
    logic [NP-1:0] prio_req;
    logic          prio_any;
    logic [3:0]    prio_idx;

    always_comb begin
        mask_ok = st_r.pend & st_r.processor_status_word[NM-1:0];
        if (!st_r.processor_status_word[intr_accept_pkg::PSW_SRV_EN]) begin
            mask_ok = '0;
        end
        // Nonmaskables above all maskables, no mask applied
        prio_req = {st_r.nmi_pend, st_r.ovf_pend, mask_ok};
    end

    intr_priority_pick #(
        .N  (NP),
        .IW (4)
    ) u_pick (
        .i_req (prio_req),
        .o_any (prio_any),
        .o_idx (prio_idx)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [EVW-1:0] ev_set;
    logic           can_ack;
    logic [3:0]     idx_m;

    always_comb begin
        st_nxt        = st_r;
        ev_set        = '0;
        idx_m         = prio_idx;
        st_nxt.disp   = 1'b0;
        st_nxt.xfer   = 1'b0;
        st_nxt.rdata  = 16'h0000;

        // Latch requests
        st_nxt.pend     = st_r.pend | i_mask_req;
        st_nxt.nmi_pend = st_r.nmi_pend | nmi_sync_r[1];
        st_nxt.ovf_pend = st_r.ovf_pend | ovf_sync_r[1];

        // Instruction completion effects
        if (i_instr_done) begin
            st_nxt.hold = is_protected(i_instr_class);
            unique case (i_instr_class)
                intr_accept_pkg::INS_SRV_OFF: begin
                    st_nxt.processor_status_word[intr_accept_pkg::PSW_SRV_EN] = 1'b0;
                end
                intr_accept_pkg::INS_SRV_ON: begin
                    st_nxt.processor_status_word[intr_accept_pkg::PSW_SRV_EN] = 1'b1;
                end
                intr_accept_pkg::INS_TS_OFF: begin
                    st_nxt.processor_status_word[intr_accept_pkg::PSW_TS_EN] = 1'b0;
                end
                intr_accept_pkg::INS_TS_ON: begin
                    st_nxt.processor_status_word[intr_accept_pkg::PSW_TS_EN] = 1'b1;
                end
                intr_accept_pkg::INS_SAVE_ALL: begin
                    st_nxt.push  = st_r.processor_status_word;
                    st_nxt.push2 = 1'b1;
                end
                intr_accept_pkg::INS_REST_ALL: begin
                    st_nxt.processor_status_word = i_pop_data;
                end
                intr_accept_pkg::INS_SAVE_FLAGS: begin
                    st_nxt.push  = {st_r.processor_status_word[15:8], 8'h00};
                    st_nxt.push2 = 1'b0;
                end
                intr_accept_pkg::INS_REST_FLAGS: begin
                    st_nxt.processor_status_word[15:8] = i_pop_data[15:8];
                end
                intr_accept_pkg::INS_UNIMP_OP: begin
                    st_nxt.disp     = 1'b1;
                    st_nxt.kind     = intr_accept_pkg::KIND_NMI;
                    st_nxt.vec      = intr_accept_pkg::VEC_UNIMP_OP;
                    ev_set[intr_accept_pkg::EV_NMI] = 1'b1;
                end
                intr_accept_pkg::INS_SW_TRAP: begin
                    st_nxt.disp     = 1'b1;
                    st_nxt.kind     = intr_accept_pkg::KIND_NMI;
                    st_nxt.vec      = intr_accept_pkg::VEC_SW_TRAP;
                    ev_set[intr_accept_pkg::EV_NMI] = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Acknowledge point
        can_ack = i_ack_point && !st_r.hold && !st_nxt.disp && prio_any;
        if (can_ack) begin
            st_nxt.disp = 1'b1;
            ev_set[intr_accept_pkg::EV_DISPATCH] = 1'b1;
            if (prio_idx == 4'(NM + 1)) begin
                st_nxt.nmi_pend = nmi_sync_r[1];
                st_nxt.kind     = intr_accept_pkg::KIND_NMI;
                st_nxt.vec      = intr_accept_pkg::VEC_NMI;
                ev_set[intr_accept_pkg::EV_NMI] = 1'b1;
            end else if (prio_idx == 4'(NM)) begin
                st_nxt.ovf_pend = ovf_sync_r[1];
                st_nxt.kind     = intr_accept_pkg::KIND_NMI;
                st_nxt.vec      = intr_accept_pkg::VEC_STACK_OVF;
                ev_set[intr_accept_pkg::EV_NMI] = 1'b1;
            end else begin
                st_nxt.pend[idx_m[2:0]] = i_mask_req[idx_m[2:0]];
                if (st_r.route[idx_m[2:0]] &&
                    st_r.processor_status_word[intr_accept_pkg::PSW_TS_EN]) begin
                    st_nxt.kind    = intr_accept_pkg::KIND_TS;
                    st_nxt.vec     = intr_accept_pkg::VEC_BASE_TS
                                     + {11'h000, idx_m, 1'b0};
                    st_nxt.ts_busy = 1'b1;
                    st_nxt.xfer    = 1'b1;
                    ev_set[intr_accept_pkg::EV_TS] = 1'b1;
                end else begin
                    st_nxt.kind = intr_accept_pkg::KIND_STD;
                    st_nxt.vec  = std_vec(idx_m);
                end
            end
        end
        if (st_r.ts_busy && i_ts_xfer_done) begin
            st_nxt.ts_busy = 1'b0;
        end
        if (st_nxt.disp) begin
            st_nxt.last_vec = st_nxt.vec;
        end

        // Register writes
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                intr_accept_pkg::OFF_PSW: begin
                    st_nxt.processor_status_word = i_reg_wdata;
                end
                intr_accept_pkg::OFF_ROUTE: begin
                    st_nxt.route = i_reg_wdata[NM-1:0];
                end
                intr_accept_pkg::OFF_IRQ_ST: begin
                    st_nxt.ev_st = st_r.ev_st & ~i_reg_wdata[EVW-1:0];
                end
                intr_accept_pkg::OFF_IRQ_MSK: begin
                    st_nxt.ev_msk = i_reg_wdata[EVW-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over clear
        st_nxt.ev_st = st_nxt.ev_st | ev_set;

        // Register reads
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                intr_accept_pkg::OFF_PSW:     st_nxt.rdata = st_r.processor_status_word;
                intr_accept_pkg::OFF_ROUTE:   st_nxt.rdata = 16'(st_r.route);
                intr_accept_pkg::OFF_PENDING: st_nxt.rdata = {5'h00, st_r.ts_busy, st_r.nmi_pend,
                                                 st_r.ovf_pend, st_r.pend};
                intr_accept_pkg::OFF_IRQ_ST:  st_nxt.rdata = 16'(st_r.ev_st);
                intr_accept_pkg::OFF_IRQ_MSK: st_nxt.rdata = 16'(st_r.ev_msk);
                intr_accept_pkg::OFF_LAST:    st_nxt.rdata = st_r.last_vec;
                default:                      st_nxt.rdata = 16'h0000;
            endcase
        end

        st_nxt.irq = |(st_nxt.ev_st & st_nxt.ev_msk);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r     <= '0;
            st_r.processor_status_word <= intr_accept_pkg::PSW_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_reg_rdata      = st_r.rdata;
    assign o_dispatch       = st_r.disp;
    assign o_dispatch_kind  = st_r.kind;
    assign o_vector_addr    = st_r.vec;
    assign o_push_data      = st_r.push;
    assign o_push_two_bytes = st_r.push2;
    assign o_ts_xfer_req    = st_r.xfer;
    assign o_irq            = st_r.irq;

endmodule

`default_nettype wire

// file: src/intr_accept_pkg.sv
// Package of constants and types for the interrupt acceptance logic
package intr_accept_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_MASKABLE = 8;
    localparam int VEC_W        = 8;
    localparam int ADDR_W       = 16;

    // ------------------------------------------------------------
    // Processor status word layout
    // ------------------------------------------------------------
    localparam int PSW_MASK_LSB  = 0;
    localparam int PSW_FLAG_LSB  = 8;
    localparam int PSW_SRV_EN    = 14;
    localparam int PSW_TS_EN     = 15;
    localparam logic [15:0] PSW_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Register offsets of the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_PSW     = 4'h0;
    localparam logic [3:0] OFF_ROUTE   = 4'h1;
    localparam logic [3:0] OFF_PENDING = 4'h2;
    localparam logic [3:0] OFF_IRQ_ST  = 4'h3;
    localparam logic [3:0] OFF_IRQ_MSK = 4'h4;
    localparam logic [3:0] OFF_LAST    = 4'h5;

    // ------------------------------------------------------------
    // Vector locations in special-purpose memory
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_BASE_STD   = 16'h2000;
    localparam logic [15:0] VEC_BASE_TS    = 16'h2040;
    localparam logic [15:0] VEC_NMI        = 16'h203E;
    localparam logic [15:0] VEC_STACK_OVF  = 16'h203C;
    localparam logic [15:0] VEC_UNIMP_OP   = 16'h2012;
    localparam logic [15:0] VEC_SW_TRAP    = 16'h2010;

    // ------------------------------------------------------------
    // Instruction class codes from the microcode engine
    // ------------------------------------------------------------
    localparam logic [3:0] INS_OTHER      = 4'h0;
    localparam logic [3:0] INS_SRV_OFF    = 4'h1;
    localparam logic [3:0] INS_SRV_ON     = 4'h2;
    localparam logic [3:0] INS_TS_OFF     = 4'h3;
    localparam logic [3:0] INS_TS_ON      = 4'h4;
    localparam logic [3:0] INS_SAVE_ALL   = 4'h5;
    localparam logic [3:0] INS_REST_ALL   = 4'h6;
    localparam logic [3:0] INS_SAVE_FLAGS = 4'h7;
    localparam logic [3:0] INS_REST_FLAGS = 4'h8;
    localparam logic [3:0] INS_UNIMP_OP   = 4'h9;
    localparam logic [3:0] INS_SW_TRAP    = 4'hA;

    // ------------------------------------------------------------
    // Dispatch kinds
    // ------------------------------------------------------------
    localparam logic [1:0] KIND_STD = 2'h0;
    localparam logic [1:0] KIND_TS  = 2'h1;
    localparam logic [1:0] KIND_NMI = 2'h2;

    // Event bits of the interrupt status register
    localparam int EV_DISPATCH = 0;
    localparam int EV_TS       = 1;
    localparam int EV_NMI      = 2;
    localparam int EV_W        = 3;

endpackage

// file: src/intr_priority_pick.sv
// Fixed priority picker for pending requests
`timescale 1ns/1ns
`default_nettype none

module intr_priority_pick #(
    parameter int N  = 10,
    parameter int IW = 4
) (
    input  wire logic [N-1:0]  i_req,
    output logic               o_any,
    output logic [IW-1:0]      o_idx
);

    // ------------------------------------------------------------
    // Highest index wins
    // ------------------------------------------------------------
    always_comb begin
        o_any = 1'b0;
        o_idx = '0;
        for (int k = 0; k < N; k++) begin
            if (i_req[k]) begin
                o_any = 1'b1;
                o_idx = IW'(k);
            end
        end
    end

endmodule

`default_nettype wire

// file: tb/intr_accept_asserts.sv
// Concurrent checks on the interrupt acceptance ports
`timescale 1ns/1ns
`default_nettype none

module intr_accept_asserts (
    input wire logic        i_clk_sys,
    input wire logic        i_nrst,
    input wire logic        i_instr_done,
    input wire logic [3:0]  i_instr_class,
    input wire logic        i_ack_point,
    input wire logic        o_dispatch,
    input wire logic [1:0]  o_dispatch_kind,
    input wire logic [15:0] o_vector_addr,
    input wire logic [15:0] o_push_data,
    input wire logic        o_push_two_bytes,
    input wire logic        o_ts_xfer_req
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic hold_r;
    logic hold_nxt;
    logic fault_done;
    assign fault_done = i_instr_done && (i_instr_class == intr_accept_pkg::INS_UNIMP_OP
        || i_instr_class == intr_accept_pkg::INS_SW_TRAP);
    assign hold_nxt = i_instr_done ? (i_instr_class >= 4'h1 && i_instr_class <= 4'h8) : hold_r;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
        end
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_disp_cause;
        o_dispatch |-> $past(i_ack_point) || $past(fault_done);
    endproperty
    a_disp_cause: assert property (p_disp_cause) else $error("dispatch without cause");
    property p_hold;
        i_ack_point && hold_r && !i_instr_done |=> !o_dispatch;
    endproperty
    a_hold: assert property (p_hold) else $error("dispatch inside hold");
    property p_unimp;
        i_instr_done && i_instr_class == intr_accept_pkg::INS_UNIMP_OP |=>
            o_dispatch && o_vector_addr == intr_accept_pkg::VEC_UNIMP_OP;
    endproperty
    a_unimp: assert property (p_unimp) else $error("bad opcode fault vector");
    property p_trap;
        i_instr_done && i_instr_class == intr_accept_pkg::INS_SW_TRAP |=>
            o_dispatch && o_vector_addr == intr_accept_pkg::VEC_SW_TRAP;
    endproperty
    a_trap: assert property (p_trap) else $error("trap vector wrong");
    property p_nm_not_ts;
        o_dispatch && o_dispatch_kind == intr_accept_pkg::KIND_NMI |-> !o_ts_xfer_req;
    endproperty
    a_nm_not_ts: assert property (p_nm_not_ts) else $error("nonmaskable sent to server");
    property p_ts_pair;
        o_ts_xfer_req |-> o_dispatch && o_dispatch_kind == intr_accept_pkg::KIND_TS;
    endproperty
    a_ts_pair: assert property (p_ts_pair) else $error("server request unpaired");
    property p_ts_vec;
        o_dispatch && o_dispatch_kind == intr_accept_pkg::KIND_TS |->
            o_ts_xfer_req && o_vector_addr[15:4] == 12'h204 && !o_vector_addr[0];
    endproperty
    a_ts_vec: assert property (p_ts_vec) else $error("server vector wrong");
    property p_std_vec;
        o_dispatch && o_dispatch_kind == intr_accept_pkg::KIND_STD |->
            o_vector_addr[15:5] == 11'h100 && !o_vector_addr[0];
    endproperty
    a_std_vec: assert property (p_std_vec) else $error("standard vector wrong");
    property p_save_all;
        i_instr_done && i_instr_class == intr_accept_pkg::INS_SAVE_ALL |=> o_push_two_bytes;
    endproperty
    a_save_all: assert property (p_save_all) else $error("save all not two bytes");
    property p_save_flags;
        i_instr_done && i_instr_class == intr_accept_pkg::INS_SAVE_FLAGS |=>
            !o_push_two_bytes && o_push_data[7:0] == 8'h00;
    endproperty
    a_save_flags: assert property (p_save_flags) else $error("save flags wrong");
endmodule

bind intr_accept intr_accept_asserts chk_u (.i_clk_sys, .i_nrst, .i_instr_done, .i_instr_class,
    .i_ack_point, .o_dispatch, .o_dispatch_kind, .o_vector_addr, .o_push_data,
    .o_push_two_bytes, .o_ts_xfer_req);

`default_nettype wire

// file: tb/cpu_engine_model.sv
// Microcode engine model facing the acceptance logic
`timescale 1ns/1ns
`default_nettype none

module cpu_engine_model (
    input  wire logic   i_clk,
    input  wire logic   i_slow,
    input  wire logic   i_ts_req,
    output logic        o_done,
    output logic [3:0]  o_class,
    output logic [15:0] o_pop,
    output logic        o_ack,
    output logic        o_ts_done
);
    int ts_cnt = 0;
    initial begin
        o_done    = 1'b0;
        o_class   = 4'h0;
        o_pop     = 16'h0000;
        o_ack     = 1'b0;
        o_ts_done = 1'b0;
    end
    // Instruction end and or acknowledge point, one cycle
    task automatic exec(input logic [3:0] c, input logic [15:0] p, input logic d, input logic a);
        @(posedge i_clk);
        o_done  <= d;
        o_class <= c;
        o_pop   <= p;
        o_ack   <= a;
        @(posedge i_clk);
        o_done  <= 1'b0;
        o_class <= ~c;
        o_pop   <= ~p;
        o_ack   <= 1'b0;
    endtask
    // One completion per server transfer, prompt or slow
    always @(posedge i_clk) begin
        o_ts_done <= (ts_cnt == 1);
        if (i_ts_req) begin
            ts_cnt <= i_slow ? 6 : 1;
        end else if (ts_cnt > 0) begin
            ts_cnt <= ts_cnt - 1;
        end
    end
endmodule

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the interrupt acceptance logic
`timescale 1ns/1ns
`default_nettype none

module testbench;
    typedef struct packed {
        logic [15:0] processor_status_word;
        logic [7:0]  route;
        logic [7:0]  req;
        logic        disp;
        logic [1:0]  kind;
        logic [15:0] vec;
    } row_s;
    logic        i_clk_sys = 1'b0;
    logic        i_nrst = 1'b0;
    logic [3:0]  i_reg_addr = 4'h0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic [7:0]  i_mask_req = 8'h00;
    logic        i_nmi_req = 1'b0;
    logic        i_stack_ovf_req = 1'b0;
    logic        slow = 1'b0;
    logic        done;
    logic [3:0]  cls;
    logic [15:0] pop;
    logic        ack;
    logic        ts_done;
    logic [15:0] o_reg_rdata;
    logic        o_dispatch;
    logic [1:0]  o_dispatch_kind;
    logic [15:0] o_vector_addr;
    logic [15:0] o_push_data;
    logic        o_push_two_bytes;
    logic        o_ts_xfer_req;
    logic        o_irq;
    int          errors = 0;
    int          n_checks = 0;
    row_s        rows [9] = '{
        '{16'h4001, 8'h00, 8'h01, 1'b1, 2'h0, 16'h2000},
        '{16'h4084, 8'h00, 8'h84, 1'b1, 2'h0, 16'h200E},
        '{16'h4084, 8'h00, 8'h00, 1'b1, 2'h0, 16'h2004},
        '{16'hC010, 8'h10, 8'h10, 1'b1, 2'h1, 16'h2048},
        '{16'h4010, 8'h10, 8'h10, 1'b1, 2'h0, 16'h2008},
        '{16'h4000, 8'h00, 8'h02, 1'b0, 2'h0, 16'h0000},
        '{16'h4002, 8'h00, 8'h00, 1'b1, 2'h0, 16'h2002},
        '{16'h00FF, 8'h00, 8'h08, 1'b0, 2'h0, 16'h0000},
        '{16'h40FF, 8'h00, 8'h00, 1'b1, 2'h0, 16'h2006}};

    intr_accept dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_mask_req(i_mask_req), .i_nmi_req(i_nmi_req),
        .i_stack_ovf_req(i_stack_ovf_req), .i_instr_done(done), .i_instr_class(cls),
        .i_pop_data(pop), .i_ack_point(ack), .i_ts_xfer_done(ts_done),
        .o_dispatch(o_dispatch), .o_dispatch_kind(o_dispatch_kind),
        .o_vector_addr(o_vector_addr), .o_push_data(o_push_data),
        .o_push_two_bytes(o_push_two_bytes), .o_ts_xfer_req(o_ts_xfer_req), .o_irq(o_irq));
    cpu_engine_model eng_u (.i_clk(i_clk_sys), .i_slow(slow), .i_ts_req(o_ts_xfer_req),
        .o_done(done), .o_class(cls), .o_pop(pop), .o_ack(ack), .o_ts_done(ts_done));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string nm);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd   <= 1'b0;
        #1;
        chk(o_reg_rdata, e, nm);
    endtask
    task automatic pulse(input logic [7:0] r);
        @(posedge i_clk_sys);
        i_mask_req <= r;
        @(posedge i_clk_sys);
        i_mask_req <= 8'h00;
    endtask
    // Kind 3 means the kind is not compared
    task automatic expect_disp(input logic d, input logic [1:0] k, input logic [15:0] v);
        logic seen;
        seen = 1'b0;
        repeat (3) begin
            #1;
            if (o_dispatch === 1'b1 && !seen) begin
                seen = 1'b1;
                if (k !== 2'h3) chk({14'h0, o_dispatch_kind}, {14'h0, k}, "kind");
                chk(o_vector_addr, v, "vector");
            end
            @(posedge i_clk_sys);
        end
        chk({15'h0, seen}, {15'h0, d}, "dispatch");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #100000;
        errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            slow <= rows[i].processor_status_word[15];
            wr(4'h0, rows[i].processor_status_word);
            wr(4'h1, {8'h00, rows[i].route});
            pulse(rows[i].req);
            eng_u.exec(4'h0, 16'h0000, 1'b0, 1'b1);
            expect_disp(rows[i].disp, rows[i].kind, rows[i].vec);
        end
        $display("test table done");
        for (int c = 1; c <= 8; c++) begin
            pulse(8'h01);
            eng_u.exec(c[3:0], 16'h40FF, 1'b1, 1'b0);
            #1;
            if (c == 5) chk({o_push_two_bytes, o_push_data[14:0]}, 16'hC0FF, "push all");
            if (c == 7) chk({o_push_two_bytes, o_push_data[14:0]}, 16'h4000, "push flags");
            eng_u.exec(4'h0, 16'h0000, 1'b0, 1'b1);
            expect_disp(1'b0, 2'h0, 16'h0000);
            if (c == 1) eng_u.exec(4'h2, 16'h0000, 1'b1, 1'b0);
            eng_u.exec(4'h0, 16'h0000, 1'b1, 1'b0);
            eng_u.exec(4'h0, 16'h0000, 1'b0, 1'b1);
            expect_disp(1'b1, 2'h0, 16'h2000);
        end
        $display("test protected done");
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h00FF);
        pulse(8'hFF);
        eng_u.exec(4'h1, 16'h0000, 1'b1, 1'b0);
        i_nmi_req <= 1'b1;
        i_stack_ovf_req <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_nmi_req <= 1'b0;
        i_stack_ovf_req <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        eng_u.exec(4'h0, 16'h0000, 1'b1, 1'b0);
        eng_u.exec(4'h0, 16'h0000, 1'b0, 1'b1);
        expect_disp(1'b1, 2'h2, 16'h203E);
        eng_u.exec(4'h0, 16'h0000, 1'b0, 1'b1);
        expect_disp(1'b1, 2'h2, 16'h203C);
        $display("test nonmaskable done");
        wr(4'h0, 16'h40FF);
        eng_u.exec(intr_accept_pkg::INS_SW_TRAP, 16'h0000, 1'b1, 1'b1);
        expect_disp(1'b1, 2'h2, 16'h2010);
        eng_u.exec(intr_accept_pkg::INS_UNIMP_OP, 16'h0000, 1'b1, 1'b0);
        expect_disp(1'b1, 2'h2, 16'h2012);
        rd(4'h2, 16'h00FF, "pending");
        $display("test faults done");
        chk({15'h0, o_irq}, 16'h0000, "irq masked");
        wr(4'h4, 16'h0004);
        @(posedge i_clk_sys);
        #1;
        chk({15'h0, o_irq}, 16'h0001, "irq raised");
        wr(4'h3, 16'h0007);
        rd(4'h3, 16'h0000, "status cleared");
        chk({15'h0, o_irq}, 16'h0000, "irq cleared");
        rd(4'hF, 16'h0000, "unmapped");
        rd(4'h5, 16'h2012, "last vector");
        $display("test registers done");
        wr(4'h0, 16'h5A3C);
        rd(4'h0, 16'h5A3C, "status word");
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk({o_dispatch, o_irq, o_ts_xfer_req, 13'h0}, 16'h0000, "reset outputs");
        chk(o_vector_addr, 16'h0000, "reset vector");
        i_nrst <= 1'b1;
        rd(4'h0, 16'h0000, "status reset");
        $display("test reset done");
        summarize();
    end
endmodule

`default_nettype wire
